// >>> rtl/pwr_pkg.sv
// Constants for the power-state and wake controller.
// Assumes a 50 MHz system clock and a one-cycle-read register port.
package pwr_pkg;
    localparam int unsigned CLK_HZ         = 50000000;
    localparam int unsigned PULSE_MS       = 50;
    localparam int unsigned READY_MS       = 2;
    localparam int unsigned PULSE_CYCLES   = CLK_HZ / 1000 * PULSE_MS;
    localparam int unsigned READY_CYCLES   = CLK_HZ / 1000 * READY_MS / 4;
    // Register offsets (byte addresses)
    localparam logic [7:0]  OFS_PMCTRL     = 8'h00;
    localparam logic [7:0]  OFS_INTSTS     = 8'h04;
    localparam logic [7:0]  OFS_BYTETEST   = 8'h08;
    localparam logic [7:0]  OFS_CLKSTAT    = 8'h0C;
    localparam logic [31:0] BYTETEST_VAL   = 32'h87654321;
    // Control register fields
    localparam int unsigned B_READY        = 0;
    localparam int unsigned B_EVT_EN       = 1;
    localparam int unsigned B_PULSE        = 3;
    localparam int unsigned B_WF_EN        = 9;
    localparam int unsigned B_ENERGY_WAKE_ENABLE        = 8;
    localparam int unsigned F_CAUSE        = 12;
    localparam int unsigned F_STATE        = 4;
    // Interrupt status fields
    localparam int unsigned B_PEV_INT      = 17;
    localparam int unsigned B_PEV_INT_EN   = 18;
    // Encodings
    localparam logic [1:0]  SEL_NORMAL     = 2'h0;
    localparam logic [1:0]  SEL_LIGHT      = 2'h1;
    localparam logic [1:0]  SEL_DEEP       = 2'h2;
    localparam logic [1:0]  CAUSE_NONE     = 2'h0;
    localparam logic [1:0]  CAUSE_ENERGY   = 2'h1;
    localparam logic [1:0]  CAUSE_FRAME    = 2'h2;
    typedef enum logic [1:0] {
        NORMAL_STATE,
        LIGHT_SLEEP_STATE,
        DEEP_SLEEP_STATE,
        WAKING_STATE
    } pstate_t;
endpackage : pwr_pkg

// >>> rtl/sync2.sv
// Two-flop synchroniser, generic width.
// Assumes inputs come from pins outside the clock domain.
`timescale 1ns/1ps
module sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_t;
    sync_t st;
    sync_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
        if (!reset_n_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign q_o = st.s2;
endmodule : sync2

// >>> rtl/power_state_wake_control.sv
// Power-state controller: normal, light and deep sleep, clock gating,
// readiness flag, wake detection, event pin and power-event status.
// Assumes wake detector pins are asynchronous; host port is synchronous.
//
// Behaviour
// - Exactly one normal state and two saving states exist.
// - In sleep only the control register is readable; all else blocked.
// - Readiness flag clears on sleep entry and stays clear while asleep.
// - Writes ignored until one read after reset or wake.
// - Byte-order register write in sleep returns to normal, resets state field.
// - Writing 01 to state field enters light sleep.
// - Light sleep gates MAC and host clocks, keeps core and PHY clocks.
// - Light sleep enables wake-frame and pattern detection automatically.
// - Light sleep wake sets cause 10b; event pin if both enables set.
// - Power-event status bit sets on any frame or carrier wake, regardless of pin enable.
// - Host interrupt output may fire on wake detection.
// - Deep sleep stops all MAC, host and core clocks; PHY energy mode.
// - Carrier already present at deep sleep entry is detected at once.
// - Deep sleep carrier sets cause 01b; event pin if both enables set.
// - Configuration and register contents survive both sleep states.
// - MAC receive power block on in light, off in deep; PHY on in light.
// - Pulse mode drives event pin 50 ms; else drives it continuously.
// - Event pin drops when cause, matching enable or pin enable clears.
// - Ready sets 0.5 ms (READY_CYCLES) after the wake write.
`timescale 1ns/1ps
module power_state_wake_control #(
    parameter int unsigned PULSE_CYCLES = pwr_pkg::PULSE_CYCLES,
    parameter int unsigned READY_CYCLES = pwr_pkg::READY_CYCLES
) (
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    input  wire logic        WAKE_FRAME_I,
    input  wire logic        CARRIER_I,
    output logic             EVENT_O,
    output logic             IRQ_O,
    output logic             MAC_HOST_CLK_EN_O,
    output logic             CORE_CLK_EN_O,
    output logic             PHY_CLK_EN_O,
    output logic             RX_PM_EN_O,
    output logic             WAKE_DETECT_EN_O
);
    localparam int unsigned CW = 32;

    typedef struct packed {
        pwr_pkg::pstate_t pstate;
        logic [1:0]       state_sel;
        logic [1:0]       cause;
        logic             ready;
        logic             read_seen;
        logic             evt_en;
        logic             pulse_mode;
        logic             wf_en;
        logic             energy_wake_enable;
        logic             pev_int;
        logic             pev_int_en;
        logic             evt;
        logic             pulse_done;
        logic [CW-1:0]    pulse_cnt;
        logic [CW-1:0]    ready_cnt;
        logic [31:0]      rdata;
        logic             irq;
        logic             mac_host_clk;
        logic             core_clk;
        logic             phy_clk;
        logic             rx_pm;
        logic             wake_det;
    } state_t;

    state_t st;
    state_t next_st;
    logic   frame_s;
    logic   carrier_s;

    // One synchroniser per pin; the two detectors are unrelated
    sync2 #(
        .WIDTH (1)
    ) u_frame_sync (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .d_i       (WAKE_FRAME_I),
        .q_o       (frame_s)
    );

    sync2 #(
        .WIDTH (1)
    ) u_carrier_sync (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .d_i       (CARRIER_I),
        .q_o       (carrier_s)
    );

    always_comb begin
        logic        asleep;
        logic        wr_ok;
        logic        wake_frame;
        logic        wake_energy;
        logic        evt_cond;
        logic [31:0] ctrl_word;
        logic [31:0] ists_word;
        logic        rd_open;
        logic        wr_ctrl;
        logic        wr_ists;
        logic        wake_wr;
        logic        wake_any;
        logic        pulse_end;
        logic        ready_end;
        asleep      = 1'b0;
        wr_ok       = 1'b0;
        wake_frame  = 1'b0;
        wake_energy = 1'b0;
        evt_cond    = 1'b0;
        ctrl_word   = '0;
        ists_word   = '0;
        rd_open     = 1'b0;
        wr_ctrl     = 1'b0;
        wr_ists     = 1'b0;
        wake_wr     = 1'b0;
        wake_any    = 1'b0;
        pulse_end   = 1'b0;
        ready_end   = 1'b0;
        next_st     = st;

        asleep = (st.pstate == pwr_pkg::LIGHT_SLEEP_STATE)
              || (st.pstate == pwr_pkg::DEEP_SLEEP_STATE);

        // Request decode shared by the read mux and the write paths
        rd_open   = !asleep && st.ready;
        wr_ok     = WR_I && st.read_seen && st.ready && !asleep;
        wr_ctrl   = wr_ok && (ADDR_I == pwr_pkg::OFS_PMCTRL);
        wr_ists   = wr_ok && (ADDR_I == pwr_pkg::OFS_INTSTS);
        // Wake write skips the read-first gate; nothing else reaches the bus
        wake_wr   = WR_I && asleep && (ADDR_I == pwr_pkg::OFS_BYTETEST);
        pulse_end = (st.pulse_cnt >= CW'(PULSE_CYCLES - 1));
        ready_end = (st.ready_cnt >= CW'(READY_CYCLES - 1));

        // Control word: ready, pin enable, pulse mode, both wake enables,
        // state select and wake cause. Ready and cause are read-only here;
        // cause clears only through a write of zero to its field.
        // Status word: power-event flag (write one to clear) and its
        // interrupt enable. Unmapped offsets read as zero.
        ctrl_word[pwr_pkg::B_READY]                 = st.ready;
        ctrl_word[pwr_pkg::B_EVT_EN]                = st.evt_en;
        ctrl_word[pwr_pkg::B_PULSE]                 = st.pulse_mode;
        ctrl_word[pwr_pkg::B_ENERGY_WAKE_ENABLE]                 = st.energy_wake_enable;
        ctrl_word[pwr_pkg::B_WF_EN]                 = st.wf_en;
        ctrl_word[pwr_pkg::F_STATE +: 2]            = st.state_sel;
        ctrl_word[pwr_pkg::F_CAUSE +: 2]            = st.cause;
        ists_word[pwr_pkg::B_PEV_INT]               = st.pev_int;
        ists_word[pwr_pkg::B_PEV_INT_EN]            = st.pev_int_en;

        // Read data valid only in the cycle after the strobe
        next_st.rdata = '0;
        if (RD_I) begin
            next_st.read_seen = 1'b1;
            if (ADDR_I == pwr_pkg::OFS_PMCTRL) begin
                next_st.rdata = ctrl_word;
            end else if (rd_open) begin
                unique case (ADDR_I)
                    pwr_pkg::OFS_INTSTS: begin
                        next_st.rdata = ists_word;
                    end
                    pwr_pkg::OFS_BYTETEST: begin
                        next_st.rdata = pwr_pkg::BYTETEST_VAL;
                    end
                    pwr_pkg::OFS_CLKSTAT: begin
                        next_st.rdata = {27'h0, st.wake_det, st.rx_pm,
                                         st.phy_clk, st.core_clk, st.mac_host_clk};
                    end
                    default: begin
                        next_st.rdata = '0;
                    end
                endcase
            end
        end

        // Writes need a prior read and full readiness
        if (wr_ctrl) begin
            next_st.evt_en     = WDATA_I[pwr_pkg::B_EVT_EN];
            next_st.pulse_mode = WDATA_I[pwr_pkg::B_PULSE];
            next_st.energy_wake_enable      = WDATA_I[pwr_pkg::B_ENERGY_WAKE_ENABLE];
            next_st.wf_en      = WDATA_I[pwr_pkg::B_WF_EN];
            if (WDATA_I[pwr_pkg::F_CAUSE +: 2] == pwr_pkg::CAUSE_NONE) begin
                next_st.cause = pwr_pkg::CAUSE_NONE;
            end
            unique case (WDATA_I[pwr_pkg::F_STATE +: 2])
                pwr_pkg::SEL_LIGHT: begin
                    next_st.pstate    = pwr_pkg::LIGHT_SLEEP_STATE;
                    next_st.state_sel = pwr_pkg::SEL_LIGHT;
                    next_st.ready     = 1'b0;
                end
                pwr_pkg::SEL_DEEP: begin
                    next_st.pstate    = pwr_pkg::DEEP_SLEEP_STATE;
                    next_st.state_sel = pwr_pkg::SEL_DEEP;
                    next_st.ready     = 1'b0;
                end
                default: ;
            endcase
        end
        if (wr_ists) begin
            next_st.pev_int_en = WDATA_I[pwr_pkg::B_PEV_INT_EN];
        end

        // Wake detection; pattern input only sampled in light sleep
        wake_frame  = (st.pstate == pwr_pkg::LIGHT_SLEEP_STATE) && frame_s;
        wake_energy = (st.pstate == pwr_pkg::DEEP_SLEEP_STATE) && carrier_s;
        wake_any    = wake_frame || wake_energy;
        if (wake_frame) begin
            next_st.cause = pwr_pkg::CAUSE_FRAME;
        end
        if (wake_energy) begin
            next_st.cause = pwr_pkg::CAUSE_ENERGY;
        end

        // Event pin condition tracks cause and its enables
        evt_cond = st.evt_en
                && ((st.cause == pwr_pkg::CAUSE_FRAME && st.wf_en)
                 || (st.cause == pwr_pkg::CAUSE_ENERGY && st.energy_wake_enable));
        // Write-one clear; a wake in the same cycle wins
        if (wr_ists && WDATA_I[pwr_pkg::B_PEV_INT]) begin
            next_st.pev_int = 1'b0;
        end
        if (wake_any) begin
            next_st.pev_int = 1'b1;
        end

        // Pulse re-arms only once the condition drops: one event, one pulse
        if (!evt_cond) begin
            next_st.evt        = 1'b0;
            next_st.pulse_done = 1'b0;
            next_st.pulse_cnt  = '0;
        end else if (st.pulse_mode) begin
            if (!st.pulse_done && !st.evt) begin
                next_st.evt       = 1'b1;
                next_st.pulse_cnt = '0;
            end else if (st.evt) begin
                if (pulse_end) begin
                    next_st.evt        = 1'b0;
                    next_st.pulse_done = 1'b1;
                end else begin
                    next_st.pulse_cnt = st.pulse_cnt + 1'b1;
                end
            end
        end else begin
            next_st.evt = 1'b1;
        end

        // Wake write: any value to byte-order register, even unread
        if (wake_wr) begin
            next_st.pstate    = pwr_pkg::WAKING_STATE;
            next_st.state_sel = pwr_pkg::SEL_NORMAL;
            next_st.ready_cnt = '0;
            next_st.read_seen = 1'b0;
        end
        // Resume wait; control reads still answer while it runs
        if (st.pstate == pwr_pkg::WAKING_STATE) begin
            if (ready_end) begin
                next_st.pstate = pwr_pkg::NORMAL_STATE;
                next_st.ready  = 1'b1;
            end else begin
                next_st.ready_cnt = st.ready_cnt + 1'b1;
            end
        end

        // Clock gates follow the next state
        unique case (next_st.pstate)
            pwr_pkg::LIGHT_SLEEP_STATE: begin
                next_st.mac_host_clk = 1'b0;
                next_st.core_clk     = 1'b1;
                next_st.phy_clk      = 1'b1;
                next_st.rx_pm        = 1'b1;
                next_st.wake_det     = 1'b1;
            end
            pwr_pkg::DEEP_SLEEP_STATE: begin
                next_st.mac_host_clk = 1'b0;
                next_st.core_clk     = 1'b0;
                next_st.phy_clk      = 1'b0;
                next_st.rx_pm        = 1'b0;
                next_st.wake_det     = 1'b0;
            end
            default: begin
                next_st.mac_host_clk = 1'b1;
                next_st.core_clk     = 1'b1;
                next_st.phy_clk      = 1'b1;
                next_st.rx_pm        = 1'b1;
                next_st.wake_det     = 1'b0;
            end
        endcase

        next_st.irq = next_st.pev_int && next_st.pev_int_en;

        // Config bits hold across sleep; only reset clears them
        if (!RESET_N_I) begin
            next_st.pstate       = pwr_pkg::NORMAL_STATE;
            next_st.state_sel    = pwr_pkg::SEL_NORMAL;
            next_st.cause        = pwr_pkg::CAUSE_NONE;
            next_st.ready        = 1'b1;
            next_st.read_seen    = 1'b0;
            next_st.evt_en       = 1'b0;
            next_st.pulse_mode   = 1'b0;
            next_st.wf_en        = 1'b0;
            next_st.energy_wake_enable        = 1'b0;
            next_st.pev_int      = 1'b0;
            next_st.pev_int_en   = 1'b0;
            next_st.evt          = 1'b0;
            next_st.pulse_done   = 1'b0;
            next_st.pulse_cnt    = '0;
            next_st.ready_cnt    = '0;
            next_st.rdata        = '0;
            next_st.irq          = 1'b0;
            next_st.mac_host_clk = 1'b1;
            next_st.core_clk     = 1'b1;
            next_st.phy_clk      = 1'b1;
            next_st.rx_pm        = 1'b1;
            next_st.wake_det     = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        st <= next_st;
    end

    assign RDATA_O           = st.rdata;
    assign EVENT_O           = st.evt;
    assign IRQ_O             = st.irq;
    assign MAC_HOST_CLK_EN_O = st.mac_host_clk;
    assign CORE_CLK_EN_O     = st.core_clk;
    assign PHY_CLK_EN_O      = st.phy_clk;
    assign RX_PM_EN_O        = st.rx_pm;
    assign WAKE_DETECT_EN_O  = st.wake_det;
endmodule : power_state_wake_control

// >>> test/power_state_wake_control_sva.sv
// Port checker for the power-state and wake controller.
// Assumes one clock domain and a host that stays quiet while asleep.
`timescale 1ns/1ps
module power_state_wake_control_sva #(
    parameter int unsigned PULSE_CYCLES = 20,
    parameter int unsigned READY_CYCLES = 10
) (
    input wire logic        CLK_I,
    input wire logic        RESET_N_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        EVENT_O,
    input wire logic        MAC_HOST_CLK_EN_O,
    input wire logic        CORE_CLK_EN_O,
    input wire logic        PHY_CLK_EN_O,
    input wire logic        RX_PM_EN_O,
    input wire logic        WAKE_DETECT_EN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // A wake write re-arms the read-before-write gate
    logic seen_rd;
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I || (WR_I && ADDR_I == pwr_pkg::OFS_BYTETEST && !MAC_HOST_CLK_EN_O)) begin
            seen_rd <= 1'b0;
        end else if (RD_I) begin
            seen_rd <= 1'b1;
        end
    end

    // Cycles since the last wake write, held at the resume count
    int unsigned since_wake;
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            since_wake <= READY_CYCLES;
        end else if (WR_I && ADDR_I == pwr_pkg::OFS_BYTETEST && !MAC_HOST_CLK_EN_O) begin
            since_wake <= 0;
        end else if (since_wake < READY_CYCLES) begin
            since_wake <= since_wake + 1;
        end
    end

    sequence s_wake_write;
        !MAC_HOST_CLK_EN_O && WR_I && ADDR_I == pwr_pkg::OFS_BYTETEST;
    endsequence
    sequence s_clocks_back;
        ##[1:3] (MAC_HOST_CLK_EN_O && CORE_CLK_EN_O);
    endsequence

    a_deep_all_off: assert property (!CORE_CLK_EN_O |-> !MAC_HOST_CLK_EN_O && !RX_PM_EN_O)
        else $error("deep sleep left a block clock running");
    a_light_keeps_on: assert property (!MAC_HOST_CLK_EN_O && CORE_CLK_EN_O
        |-> PHY_CLK_EN_O && RX_PM_EN_O && WAKE_DETECT_EN_O)
        else $error("light sleep stopped phy, rx or detection");
    a_sleep_reads_zero: assert property (RD_I && ADDR_I != pwr_pkg::OFS_PMCTRL
        && !MAC_HOST_CLK_EN_O |=> RDATA_O == 32'h0)
        else $error("blocked read returned data");
    a_wake_write: assert property (s_wake_write |-> s_clocks_back)
        else $error("wake write did not restore clocks");
    a_event_in_sleep: assert property ($rose(EVENT_O) |-> !MAC_HOST_CLK_EN_O)
        else $error("event pin rose outside sleep");
    a_sleep_by_write: assert property ($fell(MAC_HOST_CLK_EN_O)
        |-> $past(WR_I) && $past(ADDR_I) == pwr_pkg::OFS_PMCTRL)
        else $error("sleep entered without control write");
    a_sleep_holds: assert property (!MAC_HOST_CLK_EN_O && !WR_I && !$past(WR_I)
        |=> !MAC_HOST_CLK_EN_O)
        else $error("sleep left without wake write");
    a_read_first: assert property ($fell(MAC_HOST_CLK_EN_O) |-> seen_rd)
        else $error("write acted on before any read");
    a_ready_after_wake: assert property (RD_I && ADDR_I == pwr_pkg::OFS_PMCTRL
        && MAC_HOST_CLK_EN_O && since_wake >= READY_CYCLES |=> RDATA_O[0])
        else $error("ready not set after resume time");
endmodule : power_state_wake_control_sva

bind power_state_wake_control power_state_wake_control_sva #(
    .PULSE_CYCLES(PULSE_CYCLES), .READY_CYCLES(READY_CYCLES)) sva_u (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .EVENT_O(EVENT_O), .MAC_HOST_CLK_EN_O(MAC_HOST_CLK_EN_O),
    .CORE_CLK_EN_O(CORE_CLK_EN_O), .PHY_CLK_EN_O(PHY_CLK_EN_O), .RX_PM_EN_O(RX_PM_EN_O),
    .WAKE_DETECT_EN_O(WAKE_DETECT_EN_O));

// >>> test/host_bus_model.sv
// Host processor model: single-cycle register strobes, read data next cycle.
// Assumes the caller waits for each task to return before the next.
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] rdata_i,
    output logic      [7:0]  addr_o,
    output logic      [31:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask : rd
    // Only control reads until ready, which also opens the write gate
    task automatic wake;
        logic [31:0] d = 32'h0;
        int          n = 0;
        wr(pwr_pkg::OFS_BYTETEST, 32'h0);
        while (d[0] !== 1'b1 && n < 40) begin
            rd(pwr_pkg::OFS_PMCTRL, d);
            n++;
        end
    endtask : wake
endmodule : host_bus_model

// >>> test/power_state_wake_control_tb.sv
// Self-checking bench for the power-state and wake controller.
// Assumes short pulse and ready counts so the run stays brief.
`timescale 1ns/1ps
module power_state_wake_control_tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        wake_frame = 1'b0;
    logic        carrier = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic        wr;
    logic        rd;
    logic        event_pin;
    logic        irq;
    logic [4:0]  en;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;

    power_state_wake_control #(.PULSE_CYCLES(20), .READY_CYCLES(10)) dut_u (
        .CLK_I(clk), .RESET_N_I(reset_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .WAKE_FRAME_I(wake_frame), .CARRIER_I(carrier),
        .EVENT_O(event_pin), .IRQ_O(irq), .MAC_HOST_CLK_EN_O(en[0]), .CORE_CLK_EN_O(en[1]),
        .PHY_CLK_EN_O(en[2]), .RX_PM_EN_O(en[3]), .WAKE_DETECT_EN_O(en[4]));
    host_bus_model host_u (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));

    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic t_reset;
        host_u.wr(pwr_pkg::OFS_PMCTRL, 32'h00000302);
        host_u.rd(pwr_pkg::OFS_PMCTRL, rv);
        chk(rv, 32'h00000001);
        host_u.rd(pwr_pkg::OFS_BYTETEST, rv);
        chk(rv, pwr_pkg::BYTETEST_VAL);
        chk({27'h0, en}, 32'h0000000F);
    endtask : t_reset
    // Continuous event mode, frame wake, then status, irq and cause clearing
    task automatic t_light;
        host_u.wr(pwr_pkg::OFS_PMCTRL, 32'h00000212);
        tick(1);
        chk({27'h0, en}, 32'h0000001E);
        host_u.rd(pwr_pkg::OFS_PMCTRL, rv);
        chk(rv, 32'h00000212);
        host_u.rd(pwr_pkg::OFS_BYTETEST, rv);
        chk(rv, 32'h0);
        @(posedge clk);
        wake_frame <= 1'b1;
        tick(6);
        chk({31'h0, event_pin}, 32'h1);
        wake_frame <= 1'b0;
        tick(30);
        chk({31'h0, event_pin}, 32'h1);
        host_u.rd(pwr_pkg::OFS_PMCTRL, rv);
        chk(rv, 32'h00002212);
        host_u.wake();
        host_u.rd(pwr_pkg::OFS_PMCTRL, rv);
        chk(rv, 32'h00002203);
        host_u.rd(pwr_pkg::OFS_INTSTS, rv);
        chk(rv, 32'h00020000);
        host_u.wr(pwr_pkg::OFS_INTSTS, 32'h00040000);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        host_u.wr(pwr_pkg::OFS_PMCTRL, 32'h00000202);
        tick(2);
        chk({31'h0, event_pin}, 32'h0);
        host_u.wr(pwr_pkg::OFS_INTSTS, 32'h00060000);
        tick(2);
        chk({31'h0, irq}, 32'h0);
    endtask : t_light
    // Carrier already up at entry, pulsed event pin
    task automatic t_deep;
        @(posedge clk);
        carrier <= 1'b1;
        host_u.wr(pwr_pkg::OFS_PMCTRL, 32'h0000012A);
        tick(6);
        chk({27'h0, en[4:3], 2'b00, en[0]}, 32'h0);
        chk({31'h0, event_pin}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        tick(25);
        chk({31'h0, event_pin}, 32'h0);
        host_u.wake();
        host_u.rd(pwr_pkg::OFS_PMCTRL, rv);
        chk(rv, 32'h0000110B);
        carrier <= 1'b0;
    endtask : t_deep

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_light();
        t_deep();
        end_of_test();
    end
endmodule : power_state_wake_control_tb
